/* File: include/tcb_defines.svh */
`ifndef TCB_DEFINES_SVH
`define TCB_DEFINES_SVH
// Register word indexes and byte addresses (byte addresses are multiples of 4)
`define TCB_IDX_CMPB      8'h48
`define TCB_IDX_MASK      8'h6e
`define TCB_IDX_FLAG      8'h35
`define TCB_IDX_CTRL      8'h70
`define TCB_ADDR_CMPB     10'h120
`define TCB_ADDR_MASK     10'h1b8
`define TCB_ADDR_FLAG     10'h0d4
`define TCB_ADDR_CTRL     10'h1c0
// Field positions
`define TCB_BIT_CMPB      2
`define TCB_BIT_CMPA      1
`define TCB_BIT_OVF       0
`define TCB_CTRL_MODE_LSB 0
`define TCB_CTRL_GIE      2
// Reset values
`define TCB_RST_CMPB      8'h00
`define TCB_RST_MASK      3'h0
`define TCB_RST_FLAG      3'h0
`define TCB_RST_MODE      2'h0
`endif

/* File: include/tcb_pkg.sv */
package tcb_pkg;
	// Counting modes of the timer
	typedef enum logic [1:0] {
		TCB_MODE_NORMAL = 2'h0,
		TCB_MODE_CTC    = 2'h1,
		TCB_MODE_FPWM   = 2'h3,
		TCB_MODE_PPWM   = 2'h2
	} tcb_mode_t;

	// Complete block state
	typedef struct packed {
		logic [7:0] cmp_active;
		logic [7:0] cmp_buffer;
		logic [2:0] mask;
		logic [2:0] flags;
		tcb_mode_t  mode;
		logic       gie;
		logic       wave;
		logic       irq;
		logic       waitreq;
		logic       rvalid;
		logic [31:0] rdata;
	} tcb_state_t;
endpackage

/* File: hw/tcb_compare_b.sv */
// Decided for this implementation: register access over Avalon-MM.
`include "tcb_defines.svh"

module tcb_compare_b
	import tcb_pkg::*;
#(
	parameter int COUNT_W = 8
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [9:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic [31:0]      readdata,
	output logic             readdatavalid,
	output logic             waitrequest,
	input  wire logic        count_step,
	input  wire logic [7:0]  timer_count,
	input  wire logic        count_top,
	input  wire logic        count_bottom,
	input  wire logic        compare_a_event,
	input  wire logic        overflow_event,
	output logic             waveform_out_b,
	output logic             irq
);

	// Only an eight-bit count is served
	if (COUNT_W != 8) begin : g_bad_width
		$error("tcb_compare_b serves only an 8-bit count");
	end

	tcb_state_t st;
	tcb_state_t next_st;

	// Double buffering is on in the PWM modes only
	function automatic logic is_pwm(input tcb_mode_t m);
		return (m == TCB_MODE_FPWM) || (m == TCB_MODE_PPWM);
	endfunction

	logic       buffered;
	logic       match_b;
	logic       access;
	logic       wr_go;
	logic       rd_go;
	logic       rd_start;
	logic [2:0] ev;
	logic [7:0] cmp_view;

	assign buffered = is_pwm(st.mode);
	assign match_b  = count_step && (timer_count == st.cmp_active);
	assign access   = (read || write) && st.waitreq;
	assign wr_go    = write && !st.waitreq && byteenable[0];
	assign rd_go    = read && !st.waitreq;
	// Read data are captured as waitrequest drops
	assign rd_start = read && st.waitreq;
	assign ev       = {match_b, compare_a_event, overflow_event};
	assign cmp_view = buffered ? st.cmp_buffer : st.cmp_active;

	// Next state
	always_comb begin
		next_st = st;
		next_st.rvalid = 1'b0;
		// One wait cycle, then the access completes
		next_st.waitreq = !access;
		if (!st.waitreq) begin
			next_st.waitreq = 1'b1;
		end
		if (buffered && (count_top || count_bottom)) begin
			next_st.cmp_active = st.cmp_buffer;
		end
		if (match_b) begin
			next_st.wave = !st.wave;
		end
		// flag clear by one, set wins
		if (wr_go && address == `TCB_ADDR_FLAG) begin
			next_st.flags = st.flags & ~writedata[2:0];
		end
		next_st.flags = next_st.flags | ev;
		if (wr_go) begin
			case (address)
				`TCB_ADDR_CMPB: begin
					if (buffered) begin
						next_st.cmp_buffer = writedata[7:0];
					end else begin
						next_st.cmp_active = writedata[7:0];
						next_st.cmp_buffer = writedata[7:0];
					end
				end
				`TCB_ADDR_MASK: next_st.mask = writedata[2:0];
				`TCB_ADDR_CTRL: begin
					next_st.mode =
						tcb_mode_t'(writedata[`TCB_CTRL_MODE_LSB +: 2]);
					next_st.gie  = writedata[`TCB_CTRL_GIE];
				end
				default: begin
				end
			endcase
		end
		// Read data stand while waitrequest is low
		if (rd_start) begin
			next_st.rvalid = 1'b1;
			case (address)
				`TCB_ADDR_CMPB: next_st.rdata = {24'h000000, cmp_view};
				`TCB_ADDR_MASK: next_st.rdata = {29'h0, st.mask};
				`TCB_ADDR_FLAG: next_st.rdata = {29'h0, st.flags};
				`TCB_ADDR_CTRL:
					next_st.rdata = {29'h0, st.gie, st.mode};
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		next_st.irq = st.gie && |(next_st.flags & next_st.mask);
	end

	// State register
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st            <= '0;
			st.cmp_active <= `TCB_RST_CMPB;
			st.cmp_buffer <= `TCB_RST_CMPB;
			st.mask       <= `TCB_RST_MASK;
			st.flags      <= `TCB_RST_FLAG;
			st.mode       <= tcb_mode_t'(`TCB_RST_MODE);
			st.waitreq    <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign readdata      = st.rdata;
	assign readdatavalid = st.rvalid;
	assign waitrequest   = st.waitreq;
	assign waveform_out_b = st.wave;
	assign irq           = st.irq;

	// Assertions
	property p_match_flag;
		@(posedge clock) disable iff (!rst_b)
		match_b |=> st.flags[`TCB_BIT_CMPB];
	endproperty
	a_match_flag: assert property (p_match_flag)
		else $error("compare B match did not set flag");

	property p_match_wave;
		@(posedge clock) disable iff (!rst_b)
		match_b |=> (waveform_out_b != $past(waveform_out_b));
	endproperty
	a_match_wave: assert property (p_match_wave)
		else $error("waveform did not toggle on match");

	property p_direct;
		@(posedge clock) disable iff (!rst_b)
		(wr_go && address == `TCB_ADDR_CMPB && !buffered)
			|=> st.cmp_active == $past(writedata[7:0]);
	endproperty
	a_direct: assert property (p_direct)
		else $error("direct write did not reach active compare");

	property p_hold;
		@(posedge clock) disable iff (!rst_b)
		(buffered && !count_top && !count_bottom && !wr_go)
			|=> $stable(st.cmp_active);
	endproperty
	a_hold: assert property (p_hold)
		else $error("active compare changed off top or bottom");

	property p_load;
		@(posedge clock) disable iff (!rst_b)
		(buffered && count_top) |=> st.cmp_active == $past(st.cmp_buffer);
	endproperty
	a_load: assert property (p_load)
		else $error("buffer not loaded at top");

	property p_irq;
		@(posedge clock) disable iff (!rst_b)
		(st.gie && |(st.flags & st.mask)) |-> ##[0:1] irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing");

	property p_noirq;
		@(posedge clock) disable iff (!rst_b)
		irq |-> $past(st.gie);
	endproperty
	a_noirq: assert property (p_noirq)
		else $error("interrupt without global enable");

	property p_mask_rd;
		@(posedge clock) disable iff (!rst_b)
		(rd_go && address == `TCB_ADDR_MASK) |-> readdata[31:3] == 29'h0;
	endproperty
	a_mask_rd: assert property (p_mask_rd)
		else $error("reserved mask bits read nonzero");

	property p_wait;
		@(posedge clock) disable iff (!rst_b)
		(read && waitrequest) |-> ##[1:2] !waitrequest;
	endproperty
	a_wait: assert property (p_wait)
		else $error("bus access not answered");

	property p_flag_a;
		@(posedge clock) disable iff (!rst_b)
		compare_a_event |=> st.flags[`TCB_BIT_CMPA];
	endproperty
	a_flag_a: assert property (p_flag_a)
		else $error("compare A event did not set flag");

	property p_flag_ovf;
		@(posedge clock) disable iff (!rst_b)
		overflow_event |=> st.flags[`TCB_BIT_OVF];
	endproperty
	a_flag_ovf: assert property (p_flag_ovf)
		else $error("overflow event did not set flag");

	property p_flag_clr;
		@(posedge clock) disable iff (!rst_b)
		(wr_go && address == `TCB_ADDR_FLAG && ev == 3'h0)
			|=> (st.flags & $past(writedata[2:0])) == 3'h0;
	endproperty
	a_flag_clr: assert property (p_flag_clr)
		else $error("written one did not clear flag");

	property p_mask_wr;
		@(posedge clock) disable iff (!rst_b)
		(wr_go && address == `TCB_ADDR_MASK)
			|=> st.mask == $past(writedata[2:0]);
	endproperty
	a_mask_wr: assert property (p_mask_wr)
		else $error("mask write did not land");

	property p_buf_wr;
		@(posedge clock) disable iff (!rst_b)
		(wr_go && address == `TCB_ADDR_CMPB && buffered)
			|=> st.cmp_buffer == $past(writedata[7:0]);
	endproperty
	a_buf_wr: assert property (p_buf_wr)
		else $error("buffered write did not reach buffer");

	property p_no_load;
		@(posedge clock) disable iff (!rst_b)
		(!buffered && !wr_go) |=> $stable(st.cmp_active);
	endproperty
	a_no_load: assert property (p_no_load)
		else $error("active compare changed without write");

	property p_cmp_rd;
		@(posedge clock) disable iff (!rst_b)
		(rd_go && address == `TCB_ADDR_CMPB)
			|-> readdata[7:0] == $past(cmp_view);
	endproperty
	a_cmp_rd: assert property (p_cmp_rd)
		else $error("compare read shows wrong register");

	property p_rd_valid;
		@(posedge clock) disable iff (!rst_b)
		rd_go |-> readdatavalid;
	endproperty
	a_rd_valid: assert property (p_rd_valid)
		else $error("read data not valid while accepted");

	property p_quiet;
		@(posedge clock) disable iff (!rst_b)
		!count_step |=> $stable(waveform_out_b);
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("waveform changed without count step");

	property p_irq_drop;
		@(posedge clock) disable iff (!rst_b)
		!(|(st.flags & st.mask)) |-> !irq;
	endproperty
	a_irq_drop: assert property (p_irq_drop)
		else $error("interrupt without enabled flag");

	property p_wait_one;
		@(posedge clock) disable iff (!rst_b)
		!waitrequest |=> waitrequest;
	endproperty
	a_wait_one: assert property (p_wait_one)
		else $error("waitrequest low for more than one cycle");

	c_match: cover property (@(posedge clock) disable iff (!rst_b) match_b);
	c_load: cover property (@(posedge clock) disable iff (!rst_b)
		buffered && count_bottom);
	c_irq: cover property (@(posedge clock) disable iff (!rst_b) irq);
	c_direct: cover property (@(posedge clock) disable iff (!rst_b)
		wr_go && address == `TCB_ADDR_CMPB && !buffered);
	c_clear: cover property (@(posedge clock) disable iff (!rst_b)
		wr_go && address == `TCB_ADDR_FLAG);
endmodule

/* File: sim/tcb_testbench.sv */
`define CHK(n, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("wrong value %s expected %h seen %h", n, e, g); \
	end \
end

module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [9:0] a; logic [7:0] d; logic [7:0] e;} tcb_row_t;
	logic        clock = 0;
	logic        rst_b = 0;
	logic [9:0]  address = '0;
	logic        read = 0;
	logic        write = 0;
	logic [31:0] writedata = '0;
	logic [3:0]  byteenable = 4'h1;
	logic [31:0] readdata;
	logic        readdatavalid;
	logic        waitrequest;
	logic [4:0]  ev = '0;
	logic [7:0]  timer_count = '0;
	logic        waveform_out_b;
	logic        irq;
	logic [31:0] q;
	int          n_errors = 0;
	int          compares = 0;
	// Address, write value, expected readback
	tcb_row_t    rows [5] = '{'{10'h120, 8'ha5, 8'ha5},
		'{10'h1c0, 8'h01, 8'h01}, '{10'h120, 8'h10, 8'h10},
		'{10'h1b8, 8'hff, 8'h07}, '{10'h3fc, 8'h5a, 8'h00}};

	tcb_compare_b i_dut (.clock(clock), .rst_b(rst_b), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.byteenable(byteenable), .readdata(readdata),
		.readdatavalid(readdatavalid), .waitrequest(waitrequest),
		.count_step(ev[0]), .timer_count(timer_count),
		.count_top(ev[1]), .count_bottom(ev[2]),
		.compare_a_event(ev[3]), .overflow_event(ev[4]),
		.waveform_out_b(waveform_out_b), .irq(irq));

	// Clock of 10 ns
	always #5 clock = ~clock;

	// One bus access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		int i;
		@(posedge clock);
		write <= w;
		read <= !w;
		address <= a;
		writedata <= {24'h0, d};
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (waitrequest !== 1'b0);
		q = readdata;
		`CHK("wait edges", 2, i)
		if (!w) `CHK("readdatavalid", 1'b1, readdatavalid)
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] e, input string n);
		bus(1'b0, a, 8'h00);
		`CHK(n, e, q[7:0])
	endtask

	// One-cycle event pulse with a count value
	task automatic pulse(input logic [4:0] e, input logic [7:0] c);
		@(posedge clock);
		ev <= e;
		timer_count <= c;
		@(posedge clock);
		ev <= '0;
	endtask

	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask

	task automatic finish_test;
		$display("comparisons %0d, mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		#200000;
		n_errors++;
		finish_test();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		rst_b <= 1'b1;
		rd(10'h120, 8'h00, "compare reset");
		rd(10'h1b8, 8'h00, "mask reset");
		rd(10'h0d4, 8'h00, "flags reset");
		`CHK("irq reset", 1'b0, irq)
		$display("test reset done");
		foreach (rows[k]) begin
			bus(1'b1, rows[k].a, rows[k].d);
			rd(rows[k].a, rows[k].e, "readback");
		end
		$display("test table done");
		bus(1'b1, 10'h1c0, 8'h04);
		pulse(5'h01, 8'h0f);
		rd(10'h0d4, 8'h00, "no match");
		pulse(5'h01, 8'h10);
		rd(10'h0d4, 8'h04, "match flag");
		`CHK("wave", 1'b1, waveform_out_b)
		settle();
		`CHK("irq on", 1'b1, irq)
		bus(1'b1, 10'h1b8, 8'h03);
		settle();
		`CHK("irq masked", 1'b0, irq)
		pulse(5'h18, 8'h00);
		rd(10'h0d4, 8'h07, "all flags");
		bus(1'b1, 10'h0d4, 8'h07);
		rd(10'h0d4, 8'h00, "flags cleared");
		settle();
		`CHK("irq cleared", 1'b0, irq)
		pulse(5'h10, 8'h00);
		settle();
		`CHK("irq overflow", 1'b1, irq)
		bus(1'b1, 10'h1c0, 8'h00);
		settle();
		`CHK("irq global off", 1'b0, irq)
		$display("test irq done");
		bus(1'b1, 10'h0d4, 8'h07);
		bus(1'b1, 10'h1c0, 8'h03);
		bus(1'b1, 10'h120, 8'h20);
		rd(10'h120, 8'h20, "buffer read");
		pulse(5'h01, 8'h20);
		rd(10'h0d4, 8'h00, "not yet loaded");
		pulse(5'h01, 8'h10);
		rd(10'h0d4, 8'h04, "old active");
		bus(1'b1, 10'h0d4, 8'h07);
		pulse(5'h02, 8'hff);
		pulse(5'h01, 8'h20);
		rd(10'h0d4, 8'h04, "top load");
		bus(1'b1, 10'h0d4, 8'h07);
		bus(1'b1, 10'h1c0, 8'h06);
		bus(1'b1, 10'h120, 8'h30);
		pulse(5'h04, 8'h00);
		pulse(5'h01, 8'h30);
		rd(10'h0d4, 8'h04, "bottom load");
		$display("test buffering done");
		pulse(5'h11, 8'h30);
		settle();
		`CHK("wave again", 1'b1, waveform_out_b)
		`CHK("irq overflow gie", 1'b1, irq)
		@(posedge clock);
		byteenable <= 4'h0;
		bus(1'b1, 10'h120, 8'h77);
		byteenable <= 4'h1;
		rd(10'h120, 8'h30, "lane off ignored");
		@(posedge clock);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		`CHK("waitrequest reset", 1'b1, waitrequest)
		`CHK("wave reset", 1'b0, waveform_out_b)
		`CHK("irq reset again", 1'b0, irq)
		`CHK("readdatavalid reset", 1'b0, readdatavalid)
		rst_b <= 1'b1;
		rd(10'h120, 8'h00, "compare after reset");
		rd(10'h1c0, 8'h00, "control after reset");
		rd(10'h0d4, 8'h00, "flags after reset");
		$display("test reset again done");
		finish_test();
	end
endmodule
